// >>> rtl/bwpc_cfg.svh
`ifndef BWPC_CFG_SVH
`define BWPC_CFG_SVH

// ---------------------------------------------------------------
// register offsets within the configuration frame
// ---------------------------------------------------------------
`define BWPC_ADDR_W          12
`define BWPC_OFS_PART_SEL    12'h100
`define BWPC_OFS_WINDOW      12'h220
`define BWPC_OFS_STRIDE      12'h500
`define BWPC_OFS_NRW_MAP     12'h600

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define BWPC_SEL_MSB         15
`define BWPC_SEL_INTERNAL    16
`define BWPC_STRIDE_EN       31
`define BWPC_BANDWIDTH_FRACTION_WIDTH          16
`define BWPC_WIN_MSB         23
`define BWPC_WIN_INT_LSB     8
`define BWPC_WIN_FRAC_MSB    7

// ---------------------------------------------------------------
// storage size and reset values
// ---------------------------------------------------------------
`define BWPC_NUM_PART        16
`define BWPC_IDX_W           4
`define BWPC_SEL_RST         17'h00000
`define BWPC_WINDOW_RST      24'h000100
`define BWPC_STRIDE_RST      16'h0000

`endif

// >>> rtl/bwpc_pkg.sv
package bwpc_pkg;
`include "bwpc_cfg.svh"

   typedef struct packed {
      logic                        req;
      logic                        write;
      logic                        nonsecure;
      logic [`BWPC_ADDR_W-1:0]     addr;
      logic [31:0]                 wdata;
   } bwpc_access_t;

   typedef struct packed {
      logic                        stride_en;
      logic [`BWPC_BANDWIDTH_FRACTION_WIDTH-1:0]     stride_minus_one;
      logic [`BWPC_WIN_MSB:0]      window;
   } bwpc_entry_t;

   typedef struct packed {
      logic                        ack;
      logic [31:0]                 rdata;
      logic                        err_unexpected_internal;
      logic                        err_narrowed_id_range;
   } bwpc_resp_t;

   typedef struct packed {
      logic                        regulated;
      logic [`BWPC_BANDWIDTH_FRACTION_WIDTH-1:0]     stride_minus_one;
      logic [`BWPC_WIN_MSB:0]      window;
      logic                        extra_allowed;
   } bwpc_lookup_t;

   typedef struct packed {
      logic [`BWPC_SEL_INTERNAL:0] sel_s;
      logic [`BWPC_SEL_INTERNAL:0] sel_ns;
      bwpc_resp_t                  resp;
      bwpc_lookup_t                lk;
   } bwpc_state_t;

endpackage

// >>> rtl/bwpc_bank.sv
`timescale 1ns/1ps
`include "bwpc_cfg.svh"
// one security bank of per-partition settings
module bwpc_bank
   import bwpc_pkg::*;
(
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic                   wr_en,
   input  wire logic [`BWPC_IDX_W-1:0] wr_idx,
   input  wire bwpc_entry_t            wr_entry,
   input  wire logic [`BWPC_IDX_W-1:0] rd_idx,
   output bwpc_entry_t                 rd_entry,
   input  wire logic [`BWPC_IDX_W-1:0] lk_idx,
   output bwpc_entry_t                 lk_entry
);

   bwpc_entry_t mem [`BWPC_NUM_PART];

   // reads are combinational so a new selector is used at once
   assign rd_entry = mem[rd_idx];
   assign lk_entry = mem[lk_idx];

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < `BWPC_NUM_PART; i++) begin
            mem[i] <= '{stride_en: 1'b0, stride_minus_one: `BWPC_STRIDE_RST,
                        window: `BWPC_WINDOW_RST};
         end
      end else if (wr_en) begin
         mem[wr_idx] <= wr_entry;
      end
   end

endmodule

// >>> rtl/bwpc_top.sv
`timescale 1ns/1ps
`include "bwpc_cfg.svh"
module bwpc_top
   import bwpc_pkg::*;
(
   input  wire logic                   mclk,
   input  wire logic                   rst,
   // configuration frame access
   input  wire bwpc_access_t           cfg_access,
   output bwpc_resp_t                  cfg_resp,
   // capability flags of the component
   input  wire logic                   bandwidth_partitioning_present,
   input  wire logic                   stride_support_present,
   input  wire logic                   narrowing_present_flag,
   input  wire logic                   window_writable_flag,
   input  wire logic [`BWPC_WIN_MSB:0] hw_window_width,
   // settings lookup by the bandwidth regulator
   input  wire logic [`BWPC_SEL_MSB:0] lk_partition_number,
   input  wire logic                   lk_nonsecure,
   input  wire logic                   lk_over_max,
   input  wire logic                   hard_limit_flag,
   input  wire logic                   under_max_requesting,
   output bwpc_lookup_t                lk_result
);

   // register named by the current access
   typedef enum logic [2:0] {
      reg_none   = 3'b000,
      reg_sel    = 3'b001,
      reg_stride = 3'b010,
      reg_window = 3'b011,
      reg_map    = 3'b100
   } bwpc_reg_kind_t;

   bwpc_state_t st;
   bwpc_state_t next_st;

   bwpc_entry_t rd_s;
   bwpc_entry_t rd_ns;
   bwpc_entry_t lk_s;
   bwpc_entry_t lk_ns;
   bwpc_entry_t wr_entry;
   logic        wr_s;
   logic        wr_ns;

   logic [`BWPC_SEL_INTERNAL:0] sel_cur;
   logic [`BWPC_IDX_W-1:0]      idx;
   logic [`BWPC_IDX_W-1:0]      lk_idx;
   logic                        in_range;
   logic                        lk_in_range;
   logic                        stride_here;
   logic                        window_here;
   logic                        sel_here;
   logic                        hit_sel;
   logic                        hit_stride;
   logic                        hit_window;
   logic                        hit_map;
   logic                        cfg_hit;
   logic                        err_range;
   logic                        err_internal;
   logic                        access_ok;
   bwpc_entry_t                 cur;
   bwpc_entry_t                 lk_cur;
   bwpc_reg_kind_t              reg_kind;
   logic [`BWPC_SEL_INTERNAL:0] sel_wr_value;
   logic                        sel_internal_rd;
   logic [31:0]                 rd_value;
   logic [`BWPC_WIN_MSB:0]      lk_window;
   logic                        lk_extra;

   logic [`BWPC_WIN_MSB:`BWPC_WIN_INT_LSB] window_integer_us;
   logic [`BWPC_WIN_FRAC_MSB:0]            window_fraction_us;

   // ---------------------------------------------------------------
   // storage, one bank per security state
   // ---------------------------------------------------------------
   bwpc_bank u_bank_s (
      .mclk     (mclk),
      .rst      (rst),
      .wr_en    (wr_s),
      .wr_idx   (idx),
      .wr_entry (wr_entry),
      .rd_idx   (idx),
      .rd_entry (rd_s),
      .lk_idx   (lk_idx),
      .lk_entry (lk_s)
   );

   bwpc_bank u_bank_ns (
      .mclk     (mclk),
      .rst      (rst),
      .wr_en    (wr_ns),
      .wr_idx   (idx),
      .wr_entry (wr_entry),
      .rd_idx   (idx),
      .rd_entry (rd_ns),
      .lk_idx   (lk_idx),
      .lk_entry (lk_ns)
   );

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   // one kind per access keeps the hit strobes mutually exclusive
   always_comb begin
      case (cfg_access.addr)
         `BWPC_OFS_PART_SEL: begin
            reg_kind = reg_sel;
         end
         `BWPC_OFS_STRIDE: begin
            reg_kind = reg_stride;
         end
         `BWPC_OFS_WINDOW: begin
            reg_kind = reg_window;
         end
         `BWPC_OFS_NRW_MAP: begin
            reg_kind = reg_map;
         end
         default: begin
            reg_kind = reg_none;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   always_comb begin
      stride_here = bandwidth_partitioning_present & stride_support_present;
      window_here = bandwidth_partitioning_present;
      sel_here    = bandwidth_partitioning_present | narrowing_present_flag;

      // the frame the access came through picks the selector copy
      sel_cur  = cfg_access.nonsecure ? st.sel_ns : st.sel_s;
      idx      = sel_cur[`BWPC_IDX_W-1:0];
      // partitions beyond the storage read as zero and drop writes
      in_range = (sel_cur[`BWPC_SEL_MSB:`BWPC_IDX_W] == '0);
      cur      = cfg_access.nonsecure ? rd_ns : rd_s;

      hit_sel    = cfg_access.req & (reg_kind == reg_sel) & sel_here;
      hit_stride = cfg_access.req & (reg_kind == reg_stride) & stride_here;
      hit_window = cfg_access.req & (reg_kind == reg_window) & window_here;
      hit_map    = cfg_access.req & (reg_kind == reg_map) & narrowing_present_flag;
      cfg_hit    = hit_stride | hit_window;

      // internal flag only has meaning when narrowing exists
      err_range    = narrowing_present_flag & cfg_hit
                     & ~sel_cur[`BWPC_SEL_INTERNAL];
      err_internal = hit_map & sel_cur[`BWPC_SEL_INTERNAL];
      access_ok    = cfg_hit & ~err_range & in_range;
   end

   // ---------------------------------------------------------------
   // write path: read-modify-write of the selected entry
   // ---------------------------------------------------------------
   always_comb begin
      wr_entry = cur;
      if (hit_stride) begin
         wr_entry.stride_en        = cfg_access.wdata[`BWPC_STRIDE_EN];
         wr_entry.stride_minus_one = cfg_access.wdata[`BWPC_BANDWIDTH_FRACTION_WIDTH-1:0];
      end else if (hit_window) begin
         wr_entry.window           = cfg_access.wdata[`BWPC_WIN_MSB:0];
      end
      // window writes only land when software may set the window
      wr_s  = cfg_access.write & access_ok & ~cfg_access.nonsecure
              & (hit_stride | window_writable_flag);
      wr_ns = cfg_access.write & access_ok & cfg_access.nonsecure
              & (hit_stride | window_writable_flag);
   end

   // ---------------------------------------------------------------
   // field formatting
   // ---------------------------------------------------------------
   always_comb begin
      // hardware-owned window shows the live hardware value
      if (window_writable_flag) begin
         window_integer_us  = cur.window[`BWPC_WIN_MSB:`BWPC_WIN_INT_LSB];
         window_fraction_us = cur.window[`BWPC_WIN_FRAC_MSB:0];
      end else begin
         window_integer_us  = hw_window_width[`BWPC_WIN_MSB:`BWPC_WIN_INT_LSB];
         window_fraction_us = hw_window_width[`BWPC_WIN_FRAC_MSB:0];
      end
      // a stale internal bit must not show once narrowing is off
      sel_internal_rd = sel_cur[`BWPC_SEL_INTERNAL] & narrowing_present_flag;
      sel_wr_value    = {cfg_access.wdata[`BWPC_SEL_INTERNAL] & narrowing_present_flag,
                         cfg_access.wdata[`BWPC_SEL_MSB:0]};
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   // absent, out-of-range and errored reads all return zero
   always_comb begin
      rd_value = 32'h0000_0000;
      case (reg_kind)
         reg_sel: begin
            if (hit_sel) begin
               rd_value = {15'h0000, sel_internal_rd, sel_cur[`BWPC_SEL_MSB:0]};
            end
         end
         reg_stride: begin
            if (access_ok) begin
               rd_value = {cur.stride_en, 15'h0000, cur.stride_minus_one};
            end
         end
         reg_window: begin
            if (access_ok) begin
               rd_value = {8'h00, window_integer_us, window_fraction_us};
            end
         end
         default: begin
            rd_value = 32'h0000_0000;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // regulator lookup
   // ---------------------------------------------------------------
   always_comb begin
      lk_idx      = lk_partition_number[`BWPC_IDX_W-1:0];
      lk_in_range = (lk_partition_number[`BWPC_SEL_MSB:`BWPC_IDX_W] == '0);
      lk_cur      = lk_nonsecure ? lk_ns : lk_s;
      if (!lk_in_range) begin
         lk_cur = '{stride_en: 1'b0, stride_minus_one: `BWPC_STRIDE_RST,
                    window: `BWPC_WINDOW_RST};
      end
      if (window_writable_flag) begin
         lk_window = lk_cur.window;
      end else begin
         lk_window = hw_window_width;
      end
      // beyond its maximum a partition takes only spare bandwidth, or none under a hard limit
      if (!lk_over_max) begin
         lk_extra = 1'b1;
      end else if (hard_limit_flag) begin
         lk_extra = 1'b0;
      end else begin
         lk_extra = ~under_max_requesting;
      end
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.resp.ack                     = cfg_access.req;
      next_st.resp.rdata                   = '0;
      next_st.resp.err_unexpected_internal = err_internal;
      next_st.resp.err_narrowed_id_range   = err_range;

      if (hit_sel && cfg_access.write) begin
         if (cfg_access.nonsecure) begin
            next_st.sel_ns = sel_wr_value;
         end else begin
            next_st.sel_s  = sel_wr_value;
         end
      end
      // errored reads fall through with zero data
      if (!cfg_access.write) begin
         next_st.resp.rdata = rd_value;
      end

      next_st.lk.regulated        = lk_cur.stride_en & stride_here;
      next_st.lk.stride_minus_one = lk_cur.stride_minus_one;
      next_st.lk.window           = lk_window;
      next_st.lk.extra_allowed    = lk_extra;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st        <= '0;
         st.sel_s  <= `BWPC_SEL_RST;
         st.sel_ns <= `BWPC_SEL_RST;
         st.lk.window <= `BWPC_WINDOW_RST;
      end else begin
         st <= next_st;
      end
   end

   assign cfg_resp  = st.resp;
   assign lk_result = st.lk;

endmodule

// >>> test/bwpc_checker.sv
`timescale 1ns/1ps
module bwpc_checker
   import bwpc_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire bwpc_access_t cfg_access,
   input  wire bwpc_resp_t   cfg_resp,
   input  wire logic         bandwidth_partitioning_present,
   input  wire logic         stride_support_present,
   input  wire logic         narrowing_present_flag,
   input  wire logic         window_writable_flag,
   input  wire logic [23:0]  hw_window_width,
   input  wire logic [15:0]  lk_partition_number,
   input  wire logic         lk_nonsecure,
   input  wire logic         lk_over_max,
   input  wire logic         hard_limit_flag,
   input  wire logic         under_max_requesting,
   input  wire bwpc_lookup_t lk_result
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // outputs of the first edge after reset still hold reset values
   logic rst_q;
   always_ff @(posedge mclk) begin
      rst_q <= rst;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst || rst_q);

   logic rd_req;
   assign rd_req = cfg_access.req && !cfg_access.write;

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   property p_ack; cfg_access.req |=> cfg_resp.ack; endproperty
   a_ack: assert property (p_ack) else $error("no ack after request");
   property p_idle; !cfg_access.req |=> !cfg_resp.ack && cfg_resp.rdata == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("answer without request");
   property p_err_gate;
      (cfg_resp.err_unexpected_internal || cfg_resp.err_narrowed_id_range)
         |-> cfg_resp.ack && cfg_resp.rdata == 32'h0;
   endproperty
   a_err_gate: assert property (p_err_gate) else $error("error pulse misaligned");
   property p_no_nrw_err;
      cfg_access.req && !narrowing_present_flag
         |=> !cfg_resp.err_unexpected_internal && !cfg_resp.err_narrowed_id_range;
   endproperty
   a_no_nrw_err: assert property (p_no_nrw_err) else $error("error without narrowing");
   property p_sel_read;
      rd_req && cfg_access.addr == 12'h100 && !narrowing_present_flag
         |=> cfg_resp.rdata[31:16] == 16'h0;
   endproperty
   a_sel_read: assert property (p_sel_read) else $error("selector high bits set");
   property p_stride_read; rd_req && cfg_access.addr == 12'h500 |=> cfg_resp.rdata[30:16] == 15'h0;
   endproperty
   a_stride_read: assert property (p_stride_read) else $error("stride reserved bits");
   property p_win_read; rd_req && cfg_access.addr == 12'h220 |=> cfg_resp.rdata[31:24] == 8'h0;
   endproperty
   a_win_read: assert property (p_win_read) else $error("window reserved bits");
   property p_regulated;
      lk_result.regulated |-> $past(bandwidth_partitioning_present && stride_support_present);
   endproperty
   a_regulated: assert property (p_regulated) else $error("regulated while absent");
   property p_extra;
      lk_result.extra_allowed == $past(!lk_over_max || (!hard_limit_flag && !under_max_requesting));
   endproperty
   a_extra: assert property (p_extra) else $error("extra bandwidth decision wrong");
   property p_win_ro;
      !window_writable_flag && lk_partition_number < 16'h10 |=> lk_result.window == $past(hw_window_width);
   endproperty
   a_win_ro: assert property (p_win_ro) else $error("window not hardware value");

   c_write: cover property (cfg_access.req && cfg_access.write ##1 cfg_resp.ack);
   c_range: cover property (cfg_resp.err_narrowed_id_range);
   c_unexp: cover property (cfg_resp.err_unexpected_internal);
   c_reg: cover property (lk_result.regulated);
endmodule

bind bwpc_top bwpc_checker i_chk (.mclk, .rst, .cfg_access, .cfg_resp,
   .bandwidth_partitioning_present, .stride_support_present, .narrowing_present_flag,
   .window_writable_flag, .hw_window_width, .lk_partition_number, .lk_nonsecure,
   .lk_over_max, .hard_limit_flag, .under_max_requesting, .lk_result);

// >>> test/bandwidth_partition_config_tb.sv
`timescale 1ns/1ps
module bandwidth_partition_config_tb
   import bwpc_pkg::*;
();
   logic         mclk = 1'b0, rst = 1'b1;
   bwpc_access_t ca = '0;
   bwpc_resp_t   resp;
   bwpc_lookup_t lkr;
   logic         part = 1'b1, strd = 1'b1, nrw = 1'b0, wwr = 1'b1;
   logic         om = 1'b0, hl = 1'b0, um = 1'b0, lkns = 1'b0, eu, er;
   logic [23:0]  hww = 24'h000abc;
   logic [15:0]  lkn = 16'h0;
   logic [31:0]  rd;
   int           n_fail = 0, checks_done = 0, cyc = 0;

   bwpc_top i_dut (.mclk(mclk), .rst(rst), .cfg_access(ca), .cfg_resp(resp),
      .bandwidth_partitioning_present(part), .stride_support_present(strd),
      .narrowing_present_flag(nrw), .window_writable_flag(wwr), .hw_window_width(hww),
      .lk_partition_number(lkn), .lk_nonsecure(lkns), .lk_over_max(om),
      .hard_limit_flag(hl), .under_max_requesting(um), .lk_result(lkr));

   always #2 mclk = ~mclk;

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // whole run is under a hundred cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         wrap_up();
      end
   end

   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic acc(input logic w, input logic ns, input logic [11:0] a, input logic [31:0] d);
      @(negedge mclk);
      ca = '{1'b1, w, ns, a, d};
      @(negedge mclk);
      ca.req = 1'b0;
      rd = resp.rdata;
      eu = resp.err_unexpected_internal;
      er = resp.err_narrowed_id_range;
      chk(48'(resp.ack), 48'h1);
   endtask

   task automatic rdx(input logic ns, input logic [11:0] a, input logic [31:0] exp);
      acc(1'b0, ns, a, 32'h0);
      chk(48'(rd), 48'(exp));
   endtask

   task automatic lkc(input logic [15:0] k, input logic ns, input bwpc_lookup_t exp);
      @(negedge mclk);
      lkn = k;
      lkns = ns;
      @(negedge mclk);
      chk(48'(lkr), 48'(exp));
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      rdx(1'b0, 12'h100, 32'h0);
      rdx(1'b0, 12'h500, 32'h0);
      rdx(1'b0, 12'h220, 32'h100);
      $display("test reset done");
      acc(1'b1, 1'b0, 12'h100, 32'h5);
      acc(1'b1, 1'b0, 12'h500, 32'hffffffff);
      acc(1'b1, 1'b0, 12'h220, 32'hff123456);
      rdx(1'b0, 12'h500, 32'h8000ffff);
      rdx(1'b0, 12'h220, 32'h00123456);
      acc(1'b1, 1'b1, 12'h100, 32'h5);
      rdx(1'b1, 12'h500, 32'h0);
      acc(1'b1, 1'b1, 12'h500, 32'h3);
      rdx(1'b0, 12'h500, 32'h8000ffff);
      acc(1'b1, 1'b0, 12'h100, 32'h00010009);
      rdx(1'b0, 12'h100, 32'h9);
      rdx(1'b0, 12'h500, 32'h0);
      rdx(1'b0, 12'h004, 32'h0);
      acc(1'b1, 1'b0, 12'h100, 32'h15);
      acc(1'b1, 1'b0, 12'h500, 32'h0);
      rdx(1'b0, 12'h500, 32'h0);
      $display("test banks done");
      lkc(16'h5, 1'b0, '{1'b1, 16'hffff, 24'h123456, 1'b1});
      lkc(16'h5, 1'b1, '{1'b0, 16'h3, 24'h100, 1'b1});
      lkc(16'h15, 1'b0, '{1'b0, 16'h0, 24'h100, 1'b1});
      for (int i = 0; i < 8; i++) begin
         {om, hl, um} = i[2:0];
         lkc(16'h5, 1'b0, '{1'b1, 16'hffff, 24'h123456, !om | (!hl & !um)});
      end
      {om, hl, um} = 3'h0;
      $display("test lookup done");
      acc(1'b1, 1'b0, 12'h100, 32'h5);
      strd = 1'b0;
      rdx(1'b0, 12'h500, 32'h0);
      lkc(16'h5, 1'b0, '{1'b0, 16'hffff, 24'h123456, 1'b1});
      strd = 1'b1;
      part = 1'b0;
      rdx(1'b0, 12'h220, 32'h0);
      part = 1'b1;
      wwr = 1'b0;
      acc(1'b1, 1'b0, 12'h220, 32'h00777777);
      rdx(1'b0, 12'h220, 32'h00000abc);
      wwr = 1'b1;
      rdx(1'b0, 12'h220, 32'h00123456);
      $display("test capabilities done");
      nrw = 1'b1;
      acc(1'b1, 1'b0, 12'h500, 32'h0);
      chk(48'(er), 48'h1);
      rdx(1'b0, 12'h220, 32'h0);
      chk(48'(er), 48'h1);
      rdx(1'b0, 12'h600, 32'h0);
      chk(48'(eu), 48'h0);
      acc(1'b1, 1'b0, 12'h100, 32'h00010005);
      rdx(1'b0, 12'h100, 32'h00010005);
      rdx(1'b0, 12'h500, 32'h8000ffff);
      chk(48'(er), 48'h0);
      acc(1'b0, 1'b0, 12'h600, 32'h0);
      chk(48'(eu), 48'h1);
      $display("test narrowing done");
      wrap_up();
   end
endmodule
